// >>> bench/fetch_model.sv
// fetch sequencer model that presents opcode bytes to the decoder
`timescale 1ns/1ps
module fetch_model (
    input wire logic clk,
    output logic valid,
    output logic [7:0] opcode
);
    initial begin
        valid = 1'b0;
        opcode = 8'h00;
    end
    // present one byte, taken on the following edge
    task automatic present(input logic [7:0] b);
        @(posedge clk);
        valid <= 1'b1;
        opcode <= b;
    endtask
    // idle: released byte lane inverts each cycle, so it differs from the stale value after an odd count only
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            valid <= 1'b0;
            opcode <= ~opcode;
        end
    endtask
endmodule

// >>> bench/tb.sv
// testbench for the opcode matrix decoder
`timescale 1ns/1ps
module tb;
    import opdec_pkg::*;
    typedef struct packed {logic [7:0] o; decode_t d;} row_t;
    logic clk;
    logic srst;
    logic vin;
    logic [7:0] opc;
    logic dvalid;
    decode_t dec;
    int failures = 0;
    int cmp_count = 0;
    row_t rows[$] = '{
        '{8'hDA, '{OP_PUSH_INDEX_X, AM_STACK, 3'h0}}, '{8'h5A, '{OP_PUSH_INDEX_Y, AM_STACK, 3'h0}},
        '{8'hFA, '{OP_PULL_INDEX_X, AM_STACK, 3'h0}}, '{8'h7A, '{OP_PULL_INDEX_Y, AM_STACK, 3'h0}},
        '{8'h48, '{OP_PUSH_ACCUMULATOR, AM_STACK, 3'h0}}, '{8'h08, '{OP_PUSH_STATUS, AM_STACK, 3'h0}},
        '{8'h68, '{OP_PULL_ACCUMULATOR, AM_STACK, 3'h0}}, '{8'h28, '{OP_PULL_STATUS, AM_STACK, 3'h0}},
        '{8'h64, '{OP_STORE_ZERO, AM_ZP, 3'h0}}, '{8'h74, '{OP_STORE_ZERO, AM_ZP_X, 3'h0}},
        '{8'h9C, '{OP_STORE_ZERO, AM_ABS, 3'h0}}, '{8'h9E, '{OP_STORE_ZERO, AM_ABS_X, 3'h0}},
        '{8'h04, '{OP_TEST_SET_BITS, AM_ZP, 3'h0}}, '{8'h0C, '{OP_TEST_SET_BITS, AM_ABS, 3'h0}},
        '{8'h14, '{OP_TEST_CLEAR_BITS, AM_ZP, 3'h0}}, '{8'h1C, '{OP_TEST_CLEAR_BITS, AM_ABS, 3'h0}},
        '{8'hBA, '{OP_COPY_SP_TO_X, AM_IMPLIED, 3'h0}}, '{8'h9A, '{OP_COPY_X_TO_SP, AM_IMPLIED, 3'h0}},
        '{8'hAA, '{OP_COPY_ACC_TO_X, AM_IMPLIED, 3'h0}}, '{8'hA8, '{OP_COPY_ACC_TO_Y, AM_IMPLIED, 3'h0}},
        '{8'h8A, '{OP_COPY_X_TO_ACC, AM_IMPLIED, 3'h0}}, '{8'h98, '{OP_COPY_Y_TO_ACC, AM_IMPLIED, 3'h0}},
        '{8'h26, '{OP_ROTATE_LEFT, AM_ZP, 3'h0}}, '{8'h36, '{OP_ROTATE_LEFT, AM_ZP_X, 3'h0}},
        '{8'h2A, '{OP_ROTATE_LEFT, AM_ACC, 3'h0}}, '{8'h3E, '{OP_ROTATE_LEFT, AM_ABS_X, 3'h0}},
        '{8'h6E, '{OP_ROTATE_RIGHT, AM_ABS, 3'h0}}, '{8'h76, '{OP_ROTATE_RIGHT, AM_ZP_X, 3'h0}},
        '{8'h78, '{OP_SET_IRQ_DISABLE, AM_IMPLIED, 3'h0}}, '{8'h01, '{OP_OR_INTO_ACC, AM_ZP_X_IND, 3'h0}},
        '{8'h12, '{OP_OR_INTO_ACC, AM_ZP_IND, 3'h0}}, '{8'h19, '{OP_OR_INTO_ACC, AM_ABS_Y, 3'h0}},
        '{8'hF2, '{OP_SUBTRACT_BORROW, AM_ZP_IND, 3'h0}}, '{8'hE9, '{OP_SUBTRACT_BORROW, AM_IMM, 3'h0}},
        '{8'hF1, '{OP_SUBTRACT_BORROW, AM_ZP_IND_Y, 3'h0}}, '{8'hFD, '{OP_SUBTRACT_BORROW, AM_ABS_X, 3'h0}},
        '{8'h81, '{OP_STORE_ACC, AM_ZP_X_IND, 3'h0}}, '{8'h92, '{OP_STORE_ACC, AM_ZP_IND, 3'h0}},
        '{8'h96, '{OP_STORE_INDEX_X, AM_ZP_Y, 3'h0}}, '{8'h8E, '{OP_STORE_INDEX_X, AM_ABS, 3'h0}},
        '{8'h94, '{OP_STORE_INDEX_Y, AM_ZP_X, 3'h0}}, '{8'h84, '{OP_STORE_INDEX_Y, AM_ZP, 3'h0}},
        '{8'hCB, '{OP_WAIT_FOR_IRQ, AM_IMPLIED, 3'h0}}, '{8'hDB, '{OP_HALT_CORE, AM_IMPLIED, 3'h0}},
        '{8'h07, '{OP_CLEAR_MEM_BIT, AM_ZP, 3'h0}}, '{8'hF7, '{OP_SET_MEM_BIT, AM_ZP, 3'h7}},
        '{8'h03, '{OP_NONE, AM_IMPLIED, 3'h0}}, '{8'h0B, '{OP_NONE, AM_IMPLIED, 3'h0}},
        '{8'hEA, '{OP_NONE, AM_IMPLIED, 3'h0}}, '{8'h44, '{OP_NONE, AM_IMPLIED, 3'h0}}
    }; // in row order
    opcode_matrix_decoder u_opcode_matrix_decoder (.I_REF_CLK(clk), .I_SRST(srst),
        .i_opcode_valid(vin), .i_opcode(opc), .o_decode_valid(dvalid), .o_decode(dec));
    fetch_model u_fetch_model (.clk(clk), .valid(vin), .opcode(opc));
    task automatic chk_dec(input decode_t got, input decode_t exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        failures++;
        summarize();
    end
    initial begin
        srst = 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        // back-to-back table, each answer one cycle after its byte
        for (int i = 0; i <= rows.size(); i++) begin
            if (i < rows.size()) begin
                u_fetch_model.present(rows[i].o);
            end else begin
                u_fetch_model.idle(1);
            end
            if (i > 0) begin
                #1;
                chk_bit(dvalid, 1'b1);
                chk_dec(dec, rows[i-1].d);
            end
        end
        // reset wins over a byte presented in the same cycle
        u_fetch_model.present(8'hDA);
        srst <= 1'b1;
        u_fetch_model.idle(1);
        #1;
        chk_bit(dvalid, 1'b0);
        chk_dec(dec, DECODE_RESET);
        srst <= 1'b0;
        // slow partner: decode stands while idle
        u_fetch_model.present(8'h87);
        u_fetch_model.idle(1);
        #1;
        chk_bit(dvalid, 1'b1);
        u_fetch_model.idle(3);
        #1;
        chk_bit(dvalid, 1'b0);
        chk_dec(dec, '{OP_SET_MEM_BIT, AM_ZP, 3'h0});
        summarize();
    end
endmodule

// >>> verilog/opcode_matrix_decoder.sv
// opcode matrix decoder: opcode byte to operation and addressing mode
`timescale 1ns/1ps
module opcode_matrix_decoder
    import opdec_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic i_opcode_valid,
    input wire logic [7:0] i_opcode,
    output logic o_decode_valid,
    output decode_t o_decode
);
    wire [3:0] row = i_opcode[7:4];
    wire [3:0] col = i_opcode[3:0];
    wire [2:0] bit_sel = row[2:0];
    decode_t next_decode;

    always_comb begin
        next_decode = '{OP_NONE, AM_NONE, 3'h0};
        case (col)
            4'h1: begin
                next_decode.mode = row[0] ? AM_ZP_IND_Y : AM_ZP_X_IND;
            end
            4'h2: begin
                if (row[0]) begin
                    next_decode.mode = AM_ZP_IND;
                end
            end
            4'h5: begin
                next_decode.mode = row[0] ? AM_ZP_X : AM_ZP;
            end
            4'h9: begin
                next_decode.mode = row[0] ? AM_ABS_Y : AM_IMM;
            end
            4'hD: begin
                next_decode.mode = row[0] ? AM_ABS_X : AM_ABS;
            end
            default: begin
                next_decode.mode = AM_NONE;
            end
        endcase
        if ((row == 4'h0 || row == 4'h1) && (col == 4'h1 || col == 4'h5 || col == 4'h9
            || col == 4'hD || (col == 4'h2 && row == 4'h1))) begin
            next_decode.op = OP_OR_INTO_ACC;
        end else if ((row == 4'hE || row == 4'hF) && (col == 4'h1 || col == 4'h5
            || col == 4'h9 || col == 4'hD || (col == 4'h2 && row == 4'hF))) begin
            next_decode.op = OP_SUBTRACT_BORROW;
        end else if ((row == 4'h8 || row == 4'h9) && (col == 4'h1 || col == 4'h5
            || col == 4'hD || (row == 4'h9 && (col == 4'h2 || col == 4'h9)))) begin
            next_decode.op = OP_STORE_ACC;
        end else if (col == 4'h7) begin
            next_decode.op = row[3] ? OP_SET_MEM_BIT : OP_CLEAR_MEM_BIT;
            next_decode.mode = AM_ZP;
            next_decode.bit_index = bit_sel;
        end else begin
            next_decode.mode = AM_NONE;
            case (i_opcode)
                8'hDA: next_decode = '{OP_PUSH_INDEX_X, AM_STACK, 3'h0};
                8'h5A: next_decode = '{OP_PUSH_INDEX_Y, AM_STACK, 3'h0};
                8'hFA: next_decode = '{OP_PULL_INDEX_X, AM_STACK, 3'h0};
                8'h7A: next_decode = '{OP_PULL_INDEX_Y, AM_STACK, 3'h0};
                8'h48: next_decode = '{OP_PUSH_ACCUMULATOR, AM_STACK, 3'h0};
                8'h08: next_decode = '{OP_PUSH_STATUS, AM_STACK, 3'h0};
                8'h68: next_decode = '{OP_PULL_ACCUMULATOR, AM_STACK, 3'h0};
                8'h28: next_decode = '{OP_PULL_STATUS, AM_STACK, 3'h0};
                8'h64: next_decode = '{OP_STORE_ZERO, AM_ZP, 3'h0};
                8'h74: next_decode = '{OP_STORE_ZERO, AM_ZP_X, 3'h0};
                8'h9C: next_decode = '{OP_STORE_ZERO, AM_ABS, 3'h0};
                8'h9E: next_decode = '{OP_STORE_ZERO, AM_ABS_X, 3'h0};
                8'h04: next_decode = '{OP_TEST_SET_BITS, AM_ZP, 3'h0};
                8'h0C: next_decode = '{OP_TEST_SET_BITS, AM_ABS, 3'h0};
                8'h14: next_decode = '{OP_TEST_CLEAR_BITS, AM_ZP, 3'h0};
                8'h1C: next_decode = '{OP_TEST_CLEAR_BITS, AM_ABS, 3'h0};
                8'hBA: next_decode = '{OP_COPY_SP_TO_X, AM_IMPLIED, 3'h0};
                8'h9A: next_decode = '{OP_COPY_X_TO_SP, AM_IMPLIED, 3'h0};
                8'hAA: next_decode = '{OP_COPY_ACC_TO_X, AM_IMPLIED, 3'h0};
                8'hA8: next_decode = '{OP_COPY_ACC_TO_Y, AM_IMPLIED, 3'h0};
                8'h8A: next_decode = '{OP_COPY_X_TO_ACC, AM_IMPLIED, 3'h0};
                8'h98: next_decode = '{OP_COPY_Y_TO_ACC, AM_IMPLIED, 3'h0};
                8'h26: next_decode = '{OP_ROTATE_LEFT, AM_ZP, 3'h0};
                8'h36: next_decode = '{OP_ROTATE_LEFT, AM_ZP_X, 3'h0};
                8'h2A: next_decode = '{OP_ROTATE_LEFT, AM_ACC, 3'h0};
                8'h2E: next_decode = '{OP_ROTATE_LEFT, AM_ABS, 3'h0};
                8'h3E: next_decode = '{OP_ROTATE_LEFT, AM_ABS_X, 3'h0};
                8'h66: next_decode = '{OP_ROTATE_RIGHT, AM_ZP, 3'h0};
                8'h76: next_decode = '{OP_ROTATE_RIGHT, AM_ZP_X, 3'h0};
                8'h6A: next_decode = '{OP_ROTATE_RIGHT, AM_ACC, 3'h0};
                8'h6E: next_decode = '{OP_ROTATE_RIGHT, AM_ABS, 3'h0};
                8'h7E: next_decode = '{OP_ROTATE_RIGHT, AM_ABS_X, 3'h0};
                8'h78: next_decode = '{OP_SET_IRQ_DISABLE, AM_IMPLIED, 3'h0};
                8'h86: next_decode = '{OP_STORE_INDEX_X, AM_ZP, 3'h0};
                8'h8E: next_decode = '{OP_STORE_INDEX_X, AM_ABS, 3'h0};
                8'h96: next_decode = '{OP_STORE_INDEX_X, AM_ZP_Y, 3'h0};
                8'h84: next_decode = '{OP_STORE_INDEX_Y, AM_ZP, 3'h0};
                8'h8C: next_decode = '{OP_STORE_INDEX_Y, AM_ABS, 3'h0};
                8'h94: next_decode = '{OP_STORE_INDEX_Y, AM_ZP_X, 3'h0};
                8'hCB: next_decode = '{OP_WAIT_FOR_IRQ, AM_IMPLIED, 3'h0};
                8'hDB: next_decode = '{OP_HALT_CORE, AM_IMPLIED, 3'h0};
                default: begin
                    next_decode.op = (col == 4'h3 || col == 4'hB) ? OP_NONE : OP_OTHER;
                    next_decode.mode = (col == 4'h3 || col == 4'hB) ? AM_IMPLIED : AM_NONE;
                end
            endcase
        end
        if ((col == 4'h2 && !row[0] && row != 4'hA) || (col == 4'h4 && (row == 4'h4
            || row == 4'h5 || row == 4'hD || row == 4'hF)) || (col == 4'hC
            && (row == 4'h5 || row == 4'hD || row == 4'hF))) begin
            next_decode = '{OP_NONE, AM_IMPLIED, 3'h0};
        end
        if (i_opcode == NOP_OPCODE) begin
            next_decode = '{OP_NONE, AM_IMPLIED, 3'h0};
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            o_decode <= DECODE_RESET;
            o_decode_valid <= 1'b0;
        end else begin
            o_decode_valid <= i_opcode_valid;
            if (i_opcode_valid) begin
                o_decode <= next_decode;
            end
        end
    end

    chk_push_x_decode: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        i_opcode_valid && i_opcode == 8'hDA |=> o_decode.op == OP_PUSH_INDEX_X
        && o_decode.mode == AM_STACK) else $error("push x decode wrong");
    chk_push_y_decode: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        i_opcode_valid && i_opcode == 8'h5A |=> o_decode.op == OP_PUSH_INDEX_Y)
        else $error("push y decode wrong");
    chk_pull_x_decode: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        i_opcode_valid && i_opcode == 8'hFA |=> o_decode.op == OP_PULL_INDEX_X)
        else $error("pull x decode wrong");
    chk_pull_y_decode: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        i_opcode_valid && i_opcode == 8'h7A |=> o_decode.op == OP_PULL_INDEX_Y)
        else $error("pull y decode wrong");
    chk_or_acc_rows: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        o_decode_valid && o_decode.op == OP_OR_INTO_ACC |-> $past(i_opcode[7:5]) == 3'h0)
        else $error("or decoded outside rows 0 and 1");
    chk_sbc_rows: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        o_decode_valid && o_decode.op == OP_SUBTRACT_BORROW |-> $past(i_opcode[7:5]) == 3'h7)
        else $error("subtract decoded outside rows E and F");
    chk_store_acc_noimm: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        o_decode_valid && o_decode.op == OP_STORE_ACC |-> o_decode.mode != AM_IMM)
        else $error("accumulator store has immediate mode");
    chk_bit_op_index: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        i_opcode_valid && i_opcode[3:0] == 4'h7 |=> o_decode.bit_index == $past(i_opcode[6:4])
        && o_decode.op == ($past(i_opcode[7]) ? OP_SET_MEM_BIT : OP_CLEAR_MEM_BIT))
        else $error("bit op index wrong");
    chk_col3_noop: assert property (@(posedge I_REF_CLK) disable iff (I_SRST)
        i_opcode_valid && i_opcode[3:0] == 4'h3 |=> o_decode.op == OP_NONE)
        else $error("column 3 not a no-op");

    // one byte taken by the decoder
    sequence byte_taken(logic [7:0] b);
        i_opcode_valid && i_opcode == b;
    endsequence
    // the byte taken gives this operation and mode on the next edge
    property decodes_to(logic [7:0] b, operation_t op, addr_mode_t md);
        @(posedge I_REF_CLK) disable iff (I_SRST)
        byte_taken(b) |=> o_decode.op == op && o_decode.mode == md;
    endproperty

    // accumulator and status stack ops
    chk_push_acc: assert property (
        decodes_to(8'h48, OP_PUSH_ACCUMULATOR, AM_STACK))
        else $error("push acc decode wrong");
    chk_push_status: assert property (
        decodes_to(8'h08, OP_PUSH_STATUS, AM_STACK))
        else $error("push status decode wrong");
    chk_pull_acc: assert property (
        decodes_to(8'h68, OP_PULL_ACCUMULATOR, AM_STACK))
        else $error("pull acc decode wrong");
    chk_pull_status: assert property (
        decodes_to(8'h28, OP_PULL_STATUS, AM_STACK))
        else $error("pull status decode wrong");

    // store zero modes
    chk_zero_zp: assert property (
        decodes_to(8'h64, OP_STORE_ZERO, AM_ZP))
        else $error("store zero zp wrong");
    chk_zero_zpx: assert property (
        decodes_to(8'h74, OP_STORE_ZERO, AM_ZP_X))
        else $error("store zero zp x wrong");
    chk_zero_abs: assert property (
        decodes_to(8'h9C, OP_STORE_ZERO, AM_ABS))
        else $error("store zero abs wrong");
    chk_zero_absx: assert property (
        decodes_to(8'h9E, OP_STORE_ZERO, AM_ABS_X))
        else $error("store zero abs x wrong");

    // test and modify bits
    chk_setbits_zp: assert property (
        decodes_to(8'h04, OP_TEST_SET_BITS, AM_ZP))
        else $error("test set bits zp wrong");
    chk_setbits_abs: assert property (
        decodes_to(8'h0C, OP_TEST_SET_BITS, AM_ABS))
        else $error("test set bits abs wrong");
    chk_clrbits_zp: assert property (
        decodes_to(8'h14, OP_TEST_CLEAR_BITS, AM_ZP))
        else $error("test clear bits zp wrong");
    chk_clrbits_abs: assert property (
        decodes_to(8'h1C, OP_TEST_CLEAR_BITS, AM_ABS))
        else $error("test clear bits abs wrong");

    // register copies
    chk_sp_to_x: assert property (
        decodes_to(8'hBA, OP_COPY_SP_TO_X, AM_IMPLIED))
        else $error("sp to x decode wrong");
    chk_x_to_sp: assert property (
        decodes_to(8'h9A, OP_COPY_X_TO_SP, AM_IMPLIED))
        else $error("x to sp decode wrong");
    chk_acc_to_x: assert property (
        decodes_to(8'hAA, OP_COPY_ACC_TO_X, AM_IMPLIED))
        else $error("acc to x decode wrong");
    chk_acc_to_y: assert property (
        decodes_to(8'hA8, OP_COPY_ACC_TO_Y, AM_IMPLIED))
        else $error("acc to y decode wrong");
    chk_x_to_acc: assert property (
        decodes_to(8'h8A, OP_COPY_X_TO_ACC, AM_IMPLIED))
        else $error("x to acc decode wrong");
    chk_y_to_acc: assert property (
        decodes_to(8'h98, OP_COPY_Y_TO_ACC, AM_IMPLIED))
        else $error("y to acc decode wrong");

    // rotate left modes
    chk_rotl_zp: assert property (
        decodes_to(8'h26, OP_ROTATE_LEFT, AM_ZP))
        else $error("rotate left zp wrong");
    chk_rotl_zpx: assert property (
        decodes_to(8'h36, OP_ROTATE_LEFT, AM_ZP_X))
        else $error("rotate left zp x wrong");
    chk_rotl_acc: assert property (
        decodes_to(8'h2A, OP_ROTATE_LEFT, AM_ACC))
        else $error("rotate left acc wrong");
    chk_rotl_abs: assert property (
        decodes_to(8'h2E, OP_ROTATE_LEFT, AM_ABS))
        else $error("rotate left abs wrong");
    chk_rotl_absx: assert property (
        decodes_to(8'h3E, OP_ROTATE_LEFT, AM_ABS_X))
        else $error("rotate left abs x wrong");

    // rotate right modes
    chk_rotr_zp: assert property (
        decodes_to(8'h66, OP_ROTATE_RIGHT, AM_ZP))
        else $error("rotate right zp wrong");
    chk_rotr_zpx: assert property (
        decodes_to(8'h76, OP_ROTATE_RIGHT, AM_ZP_X))
        else $error("rotate right zp x wrong");
    chk_rotr_acc: assert property (
        decodes_to(8'h6A, OP_ROTATE_RIGHT, AM_ACC))
        else $error("rotate right acc wrong");
    chk_rotr_abs: assert property (
        decodes_to(8'h6E, OP_ROTATE_RIGHT, AM_ABS))
        else $error("rotate right abs wrong");
    chk_rotr_absx: assert property (
        decodes_to(8'h7E, OP_ROTATE_RIGHT, AM_ABS_X))
        else $error("rotate right abs x wrong");

    // interrupt disable flag set
    chk_irq_disable: assert property (
        decodes_to(8'h78, OP_SET_IRQ_DISABLE, AM_IMPLIED))
        else $error("irq disable decode wrong");

    // or into acc modes
    chk_or_zp: assert property (
        decodes_to(8'h05, OP_OR_INTO_ACC, AM_ZP))
        else $error("or zp decode wrong");
    chk_or_ind_y: assert property (
        decodes_to(8'h11, OP_OR_INTO_ACC, AM_ZP_IND_Y))
        else $error("or ind y decode wrong");
    chk_or_abs_x: assert property (
        decodes_to(8'h1D, OP_OR_INTO_ACC, AM_ABS_X))
        else $error("or abs x decode wrong");

    // subtract with borrow modes
    chk_sub_zp: assert property (
        decodes_to(8'hE5, OP_SUBTRACT_BORROW, AM_ZP))
        else $error("subtract zp decode wrong");
    chk_sub_abs: assert property (
        decodes_to(8'hED, OP_SUBTRACT_BORROW, AM_ABS))
        else $error("subtract abs decode wrong");
    chk_sub_abs_y: assert property (
        decodes_to(8'hF9, OP_SUBTRACT_BORROW, AM_ABS_Y))
        else $error("subtract abs y decode wrong");

    // accumulator store modes
    chk_accst_zp: assert property (
        decodes_to(8'h85, OP_STORE_ACC, AM_ZP))
        else $error("acc store zp wrong");
    chk_accst_abs: assert property (
        decodes_to(8'h8D, OP_STORE_ACC, AM_ABS))
        else $error("acc store abs wrong");
    chk_accst_ind_y: assert property (
        decodes_to(8'h91, OP_STORE_ACC, AM_ZP_IND_Y))
        else $error("acc store ind y wrong");
    chk_accst_abs_y: assert property (
        decodes_to(8'h99, OP_STORE_ACC, AM_ABS_Y))
        else $error("acc store abs y wrong");

    // index register stores
    chk_xst_zp: assert property (
        decodes_to(8'h86, OP_STORE_INDEX_X, AM_ZP))
        else $error("x store zp wrong");
    chk_xst_abs: assert property (
        decodes_to(8'h8E, OP_STORE_INDEX_X, AM_ABS))
        else $error("x store abs wrong");
    chk_yst_zp: assert property (
        decodes_to(8'h84, OP_STORE_INDEX_Y, AM_ZP))
        else $error("y store zp wrong");
    chk_yst_abs: assert property (
        decodes_to(8'h8C, OP_STORE_INDEX_Y, AM_ABS))
        else $error("y store abs wrong");

    // wait and halt
    chk_wait_irq: assert property (
        decodes_to(8'hCB, OP_WAIT_FOR_IRQ, AM_IMPLIED))
        else $error("wait decode wrong");
    chk_halt_core: assert property (
        decodes_to(8'hDB, OP_HALT_CORE, AM_IMPLIED))
        else $error("halt decode wrong");

    // empty cells and the no-op byte
    chk_nop_none: assert property (
        decodes_to(NOP_OPCODE, OP_NONE, AM_IMPLIED))
        else $error("no-op byte not a no-op");
    chk_colb_none: assert property (
        decodes_to(8'h0B, OP_NONE, AM_IMPLIED))
        else $error("column b cell not a no-op");
    chk_col2_none: assert property (
        decodes_to(8'h02, OP_NONE, AM_IMPLIED))
        else $error("empty column 2 cell not a no-op");
endmodule

// >>> verilog/opdec_pkg.sv
// package of operation and addressing-mode codes for the opcode decoder
// Notes on behaviour
// - DA pushes X onto stack
// - 5A pushes Y onto stack
// - FA pulls X from stack
// - 7A pulls Y from stack
// - 48/08 push A/P, 68/28 pull them
// - store zero at 64,74,9C,9E
// - test-set bits at 04 and 0C
// - test-clear bits at 14 and 1C
// - BA copies SP to X, 9A reverse
// - AA copies A to X, A8 to Y
// - 8A copies X to A, 98 Y to A
// - rotates at 26/36/2A/2E/3E and 66..7E
// - 78 sets interrupt-disable flag
// - OR into A, rows 0 and 1
// - subtract with borrow, rows E and F
// - accumulator store, no immediate form
// - X and Y stores, 96 uses zp,Y
package opdec_pkg;
    typedef enum logic [5:0] {
        OP_NONE, OP_OTHER,
        OP_PUSH_INDEX_X, OP_PUSH_INDEX_Y, OP_PULL_INDEX_X, OP_PULL_INDEX_Y,
        OP_PUSH_ACCUMULATOR, OP_PUSH_STATUS, OP_PULL_ACCUMULATOR, OP_PULL_STATUS,
        OP_STORE_ZERO, OP_TEST_SET_BITS, OP_TEST_CLEAR_BITS,
        OP_COPY_SP_TO_X, OP_COPY_X_TO_SP, OP_COPY_ACC_TO_X, OP_COPY_ACC_TO_Y,
        OP_COPY_X_TO_ACC, OP_COPY_Y_TO_ACC, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
        OP_SET_IRQ_DISABLE, OP_OR_INTO_ACC, OP_SUBTRACT_BORROW,
        OP_STORE_ACC, OP_STORE_INDEX_X, OP_STORE_INDEX_Y,
        OP_WAIT_FOR_IRQ, OP_HALT_CORE, OP_CLEAR_MEM_BIT, OP_SET_MEM_BIT
    } operation_t;
    typedef enum logic [4:0] {
        AM_NONE, AM_IMPLIED, AM_STACK, AM_ACC, AM_IMM, AM_ZP, AM_ZP_X, AM_ZP_Y,
        AM_ABS, AM_ABS_X, AM_ABS_Y, AM_ZP_X_IND, AM_ZP_IND_Y, AM_ZP_IND
    } addr_mode_t;
    typedef struct packed {
        operation_t op;
        addr_mode_t mode;
        logic [2:0] bit_index;
    } decode_t;
    localparam logic [7:0] NOP_OPCODE = 8'hEA;
    localparam decode_t DECODE_RESET = '{OP_NONE, AM_NONE, 3'h0};
endpackage
